// [byte_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // consumer takes head
  output logic [WIDTH-1:0] out_data // head of queue
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire empty = (wr_ptr_q == rd_ptr_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule // byte_fifo
`default_nettype wire

// [modbus_master_model.sv]
/*
  Bus master model: sends request characters and decodes reply characters.
  Assumes the line it sees is already resolved, idling high when released.
*/
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model #(
  parameter int BIT_DIV = 2170
) (
  input wire logic clk, // system clock
  output logic line_out, // request line to the slave
  input wire logic line_in, // resolved reply line
  output logic [7:0] rx_byte, // last reply character
  output logic rx_strobe, // one cycle per reply character
  output logic rx_bad // parity or stop error
);
  logic [9:0] sh;
  initial begin
    line_out = 1'b1;
  end
  // start, data lsb first, even parity, stop; same bit time as the slave
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] ch;
    ch = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= ch[i];
      repeat (BIT_DIV) @(posedge clk);
    end
  endtask
  initial begin
    rx_strobe = 1'b0;
    rx_bad = 1'b0;
    rx_byte = 8'h00;
    forever begin
      @(posedge clk);
      if (line_in === 1'b0) begin
        repeat (BIT_DIV / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
          repeat (BIT_DIV) @(posedge clk);
          sh[i] = line_in;
        end
        rx_byte <= sh[7:0];
        rx_bad <= (^sh[8:0] !== 1'b0) || (sh[9] !== 1'b1);
        rx_strobe <= 1'b1;
        @(posedge clk);
        rx_strobe <= 1'b0;
      end
    end
  end
endmodule // modbus_master_model
`default_nettype wire

// [modbus_pkg.sv]
/*
  Shared constants of the Modbus RTU slave: clock rate, line-rate divisors,
  station address default, function and exception codes, request byte layout,
  checksum constants and the responder state encoding.
  Assumes a single 250 MHz system clock.
*/
package modbus_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int MIN_BAUD = 2_400;
  localparam int MAX_BAUD = 115_200;
  localparam int DEFAULT_BAUD = 19_200;
  localparam int BAUD_DIV_W = 17;
  localparam logic [BAUD_DIV_W-1:0] MAX_BAUD_DIV = BAUD_DIV_W'(CLK_HZ / MIN_BAUD);
  localparam logic [BAUD_DIV_W-1:0] MIN_BAUD_DIV = BAUD_DIV_W'(CLK_HZ / MAX_BAUD);
  localparam logic [BAUD_DIV_W-1:0] DEFAULT_BAUD_DIV = BAUD_DIV_W'(CLK_HZ / DEFAULT_BAUD);
  localparam logic [7:0] DEFAULT_STATION = 8'h2A;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] MAX_READ_QTY = 16'h007D;
  localparam logic [8:0] POS_ADDR = 9'h000;
  localparam logic [8:0] POS_FC = 9'h001;
  localparam logic [8:0] POS_START_HI = 9'h002;
  localparam logic [8:0] POS_START_LO = 9'h003;
  localparam logic [8:0] POS_QTY_HI = 9'h004;
  localparam logic [8:0] POS_QTY_LO = 9'h005;
  localparam logic [8:0] POS_BCNT = 9'h006;
  localparam logic [8:0] POS_DATA = 9'h007;
  localparam logic [8:0] MIN_FRAME_LEN = 9'h004;
  localparam logic [8:0] READ_REQ_LEN = 9'h008;
  localparam logic [8:0] WRITE_HDR_LEN = 9'h009;
  localparam logic [5:0] SILENCE_BITS = 6'h27; // 3.5 characters of 11 bits, rounded up
  localparam logic [3:0] CHAR_DATA_BITS = 4'h8; // data plus parity bits minus one
  localparam logic [3:0] CHAR_TX_BITS = 4'hB;
  typedef enum logic [1:0] {R_IDLE = 2'b00, R_START = 2'b01, R_DATA = 2'b11, R_STOP = 2'b10} rx_state_type;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_WRITE = 4'b0001, S_HEAD = 4'b0011, S_FETCH = 4'b0010, S_WAIT = 4'b0110,
    S_HI = 4'b0111, S_LO = 4'b0101, S_CRCL = 4'b0100, S_CRCH = 4'b1100
  } tx_state_type;
endpackage

// [modbus_rtu_register_slave.sv]
/*
  Modbus RTU slave: character receiver with even parity, frame delimiting by
  line silence, CRC check, read-holding-register and write-multiple-register
  handling, exception answers, response FIFO and transmitter with driver enable.
  Assumes a holding-register store outside with a one-cycle synchronous read port,
  and an RS-485 transceiver whose driver is enabled by tx_oe.
*/
// Notes on behaviour
// - the line rate is set by a bit divisor anywhere from 2,400 to 115,200 baud, same rate as the master.
// - without a configured rate the link runs at 19,200 baud.
// - every value lives in one or more holding registers at consecutive addresses.
// - words go most significant first at the lowest address, each register high byte first.
// - function code 3 returns the contents of the requested holding registers.
// - function code 16 updates the addressed block of up to MAX_WR_REGS holding registers and is acknowledged; a larger block gets an exception.
// - no function other than codes 3 and 16 is ever carried out.
// - without a configured address the slave answers at station 42.
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_register_slave
  import modbus_pkg::*;
#(
  parameter int MAX_WR_REGS = 4,
  parameter int FIFO_DEPTH = 8,
  // smallest accepted bit divisor; a lower floor only makes sense with a slower clock
  parameter int MIN_DIV = int'(MIN_BAUD_DIV)
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic rx, // received line level
  output logic tx, // transmit line level
  output logic tx_oe, // transceiver driver enable
  input wire logic baud_cfg_en, // use baud_cfg_div instead of default rate
  input wire logic [modbus_pkg::BAUD_DIV_W-1:0] baud_cfg_div, // clocks per bit
  input wire logic station_cfg_en, // use station_cfg instead of default address
  input wire logic [7:0] station_cfg, // configured station address
  output logic rd_en, // holding register read strobe
  output logic [15:0] rd_addr, // holding register read address
  input wire logic [15:0] rd_data, // read word, valid the cycle after rd_en
  output logic wr_en, // holding register write strobe
  output logic [15:0] wr_addr, // holding register write address
  output logic [15:0] wr_data // holding register write word
);
  import modbus_pkg::*;

  // out-of-range divisors fall back to the default so a bad setting cannot hang the link
  wire div_in_range = (baud_cfg_div >= BAUD_DIV_W'(MIN_DIV)) && (baud_cfg_div <= MAX_BAUD_DIV);
  wire [BAUD_DIV_W-1:0] bit_div = (baud_cfg_en && div_in_range) ? baud_cfg_div : DEFAULT_BAUD_DIV;
  wire [BAUD_DIV_W-1:0] half_div = {1'b0, bit_div[BAUD_DIV_W-1:1]};
  wire [7:0] station = station_cfg_en ? station_cfg : DEFAULT_STATION;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  rx_state_type rx_state_q;
  tx_state_type st_q;
  logic [BAUD_DIV_W-1:0] rx_cnt_q;
  logic [3:0] rx_nbit_q;
  logic [8:0] rx_shift_q;
  logic [BAUD_DIV_W-1:0] idle_cnt_q;
  logic [5:0] idle_bits_q;
  logic frame_active_q;
  logic frame_bad_q;
  logic [8:0] byte_idx_q;
  logic [15:0] rx_crc_q;
  logic [7:0] f_addr_q, f_fc_q, f_bcnt_q;
  logic [15:0] f_start_q, f_qty_q;
  logic [8*2*MAX_WR_REGS-1:0] wbuf_q;
  logic tx_busy;

  // receiver: half-bit start check, then 8 data bits and parity, then stop
  wire rx_cnt_done = (rx_cnt_q == '0);
  wire char_done = (rx_state_q == R_STOP) && rx_cnt_done;
  wire char_ok = char_done && rx && !(^rx_shift_q);
  wire [7:0] rx_byte = rx_shift_q[7:0];
  wire idle_tick = (rx_state_q == R_IDLE) && (idle_cnt_q == bit_div - 1'b1);
  wire frame_end = frame_active_q && (idle_bits_q == SILENCE_BITS);
  wire line_free = (st_q == S_IDLE) && !tx_busy;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state_q <= R_IDLE;
      rx_cnt_q <= '0;
      rx_nbit_q <= '0;
      rx_shift_q <= '0;
    end else begin
      rx_cnt_q <= rx_cnt_done ? bit_div - 1'b1 : rx_cnt_q - 1'b1;
      case (rx_state_q)
        R_IDLE: begin
          rx_cnt_q <= half_div;
          if (!rx && line_free) rx_state_q <= R_START;
        end
        R_START: if (rx_cnt_done) begin
          rx_state_q <= rx ? R_IDLE : R_DATA;
          rx_nbit_q <= '0;
        end
        R_DATA: if (rx_cnt_done) begin
          rx_shift_q <= {rx, rx_shift_q[8:1]};
          rx_nbit_q <= rx_nbit_q + 1'b1;
          if (rx_nbit_q == CHAR_DATA_BITS) rx_state_q <= R_STOP;
        end
        R_STOP: if (rx_cnt_done) rx_state_q <= R_IDLE;
        default: rx_state_q <= R_IDLE;
      endcase
    end
  end

  // silence counter in bit times delimits frames
  always_ff @(posedge clk) begin
    if (rst || rx_state_q != R_IDLE) begin
      idle_cnt_q <= '0;
      idle_bits_q <= '0;
    end else begin
      idle_cnt_q <= idle_tick ? '0 : idle_cnt_q + 1'b1;
      if (idle_tick && idle_bits_q != SILENCE_BITS) idle_bits_q <= idle_bits_q + 1'b1;
    end
  end

  wire [8:0] cur_idx = frame_active_q ? byte_idx_q : POS_ADDR;
  wire [15:0] crc_base = frame_active_q ? rx_crc_q : CRC_INIT;

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_active_q <= 1'b0;
      frame_bad_q <= 1'b0;
      byte_idx_q <= '0;
      rx_crc_q <= CRC_INIT;
      f_addr_q <= '0;
      f_fc_q <= '0;
      f_bcnt_q <= '0;
      f_start_q <= '0;
      f_qty_q <= '0;
    end else if (char_done) begin
      frame_active_q <= 1'b1;
      frame_bad_q <= (frame_active_q && frame_bad_q) || !char_ok;
      rx_crc_q <= crc_step(crc_base, rx_byte);
      if (cur_idx != '1) byte_idx_q <= cur_idx + 1'b1;
      if (cur_idx == POS_ADDR) f_addr_q <= rx_byte;
      if (cur_idx == POS_FC) f_fc_q <= rx_byte;
      if (cur_idx == POS_START_HI) f_start_q[15:8] <= rx_byte;
      if (cur_idx == POS_START_LO) f_start_q[7:0] <= rx_byte;
      if (cur_idx == POS_QTY_HI) f_qty_q[15:8] <= rx_byte;
      if (cur_idx == POS_QTY_LO) f_qty_q[7:0] <= rx_byte;
      if (cur_idx == POS_BCNT) f_bcnt_q <= rx_byte;
    end else if (frame_end) begin
      frame_active_q <= 1'b0;
    end
  end

  // write payload is staged until the checksum proves the frame good
  genvar gi;
  generate
    for (gi = 0; gi < 2 * MAX_WR_REGS; gi++) begin : g_wbuf
      always_ff @(posedge clk) begin
        if (rst) wbuf_q[8*gi +: 8] <= '0;
        else if (char_done && cur_idx == POS_DATA + 9'(gi)) wbuf_q[8*gi +: 8] <= rx_byte;
      end
    end
  endgenerate

  // request decode at the end of a frame
  wire frame_ok = !frame_bad_q && (rx_crc_q == 16'h0000) && (f_addr_q == station) && (byte_idx_q >= MIN_FRAME_LEN);
  wire is_rd = (f_fc_q == FC_READ);
  wire is_wr = (f_fc_q == FC_WRITE);
  wire rd_len_ok = (byte_idx_q == READ_REQ_LEN);
  wire wr_len_ok = (byte_idx_q == WRITE_HDR_LEN + {1'b0, f_bcnt_q});
  wire rd_qty_ok = (f_qty_q != '0) && (f_qty_q <= MAX_READ_QTY);
  wire wr_qty_ok = (f_qty_q != '0) && (f_qty_q <= 16'(MAX_WR_REGS)) && (f_bcnt_q == {f_qty_q[6:0], 1'b0});
  wire accept = line_free && frame_end && frame_ok;
  wire take_rd = accept && is_rd && rd_len_ok && rd_qty_ok;
  wire take_wr = accept && is_wr && wr_len_ok && wr_qty_ok;
  wire exc_val = accept && ((is_rd && rd_len_ok && !rd_qty_ok) || (is_wr && wr_len_ok && !wr_qty_ok));
  wire exc_fn = accept && !is_rd && !is_wr;

  // responder
  logic [47:0] hdr_q;
  logic [2:0] hleft_q;
  logic do_read_q;
  logic [15:0] idx_q;
  logic [15:0] tx_crc_q;
  logic rd_en_q, wr_en_q;
  logic [15:0] rd_addr_q, wr_addr_q, wr_data_q;

  wire last_reg = (idx_q == f_qty_q - 1'b1);
  wire [15:0] reg_addr = f_start_q + idx_q;
  wire [7:0] push_byte = (st_q == S_HEAD) ? hdr_q[47:40] :
                         (st_q == S_HI) ? rd_data[15:8] :
                         (st_q == S_LO) ? rd_data[7:0] :
                         (st_q == S_CRCL) ? tx_crc_q[7:0] : tx_crc_q[15:8];
  wire push_valid = (st_q == S_HEAD) || (st_q == S_HI) || (st_q == S_LO) || (st_q == S_CRCL) || (st_q == S_CRCH);
  logic push_ready;
  wire push_fire = push_valid && push_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      hdr_q <= '0;
      hleft_q <= '0;
      do_read_q <= 1'b0;
      idx_q <= '0;
      tx_crc_q <= CRC_INIT;
      rd_en_q <= 1'b0;
      wr_en_q <= 1'b0;
      rd_addr_q <= '0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      rd_en_q <= 1'b0;
      wr_en_q <= 1'b0;
      // the checksum bytes themselves must not fold into the checksum
      if (push_fire && st_q != S_CRCL && st_q != S_CRCH) tx_crc_q <= crc_step(tx_crc_q, push_byte);
      case (st_q)
        S_IDLE: begin
          idx_q <= '0;
          tx_crc_q <= CRC_INIT;
          do_read_q <= take_rd;
          if (take_rd) begin
            hdr_q <= {f_addr_q, FC_READ, f_qty_q[6:0], 1'b0, 24'h000000};
            hleft_q <= 3'h3;
            st_q <= S_HEAD;
          end else if (take_wr) begin
            hdr_q <= {f_addr_q, FC_WRITE, f_start_q, f_qty_q};
            hleft_q <= 3'h6;
            st_q <= S_WRITE;
          end else if (exc_val || exc_fn) begin
            hdr_q <= {f_addr_q, f_fc_q | EXC_FLAG, exc_fn ? EXC_ILLEGAL_FUNC : EXC_ILLEGAL_VALUE, 24'h000000};
            hleft_q <= 3'h3;
            st_q <= S_HEAD;
          end
        end
        S_WRITE: begin
          wr_en_q <= 1'b1;
          wr_addr_q <= reg_addr;
          wr_data_q <= {wbuf_q[16*idx_q[5:0] +: 8], wbuf_q[16*idx_q[5:0] + 8 +: 8]};
          idx_q <= last_reg ? '0 : idx_q + 1'b1;
          if (last_reg) st_q <= S_HEAD;
        end
        S_HEAD: if (push_fire) begin
          hdr_q <= {hdr_q[39:0], 8'h00};
          hleft_q <= hleft_q - 1'b1;
          if (hleft_q == 3'h1) st_q <= do_read_q ? S_FETCH : S_CRCL;
        end
        S_FETCH: begin
          rd_en_q <= 1'b1;
          rd_addr_q <= reg_addr;
          st_q <= S_WAIT;
        end
        S_WAIT: st_q <= S_HI;
        S_HI: if (push_fire) st_q <= S_LO;
        S_LO: if (push_fire) begin
          idx_q <= idx_q + 1'b1;
          st_q <= last_reg ? S_CRCL : S_FETCH;
        end
        S_CRCL: if (push_fire) st_q <= S_CRCH;
        S_CRCH: if (push_fire) st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign rd_en = rd_en_q;
  assign rd_addr = rd_addr_q;
  assign wr_en = wr_en_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;

  // response bytes queue here; the slow transmitter back-pressures the responder
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [3:0] tx_nbit_q;
  logic [10:0] tx_shift_q;
  logic [BAUD_DIV_W-1:0] tx_cnt_q;
  logic tx_q, tx_oe_q;
  wire tx_load = fifo_valid && !tx_busy;
  assign tx_busy = (tx_nbit_q != '0);

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_byte),
    .out_valid(fifo_valid),
    .out_ready(tx_load),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_nbit_q <= '0;
      tx_shift_q <= '1;
      tx_cnt_q <= '0;
      tx_q <= 1'b1;
      tx_oe_q <= 1'b0;
    end else begin
      tx_oe_q <= tx_busy || fifo_valid || (st_q != S_IDLE && st_q != S_WRITE);
      if (tx_load) begin
        tx_shift_q <= {1'b1, ^fifo_data, fifo_data, 1'b0};
        tx_nbit_q <= CHAR_TX_BITS;
        tx_cnt_q <= '0;
      end else if (tx_busy) begin
        if (tx_cnt_q == '0) begin
          tx_q <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_cnt_q <= bit_div - 1'b1;
        end else begin
          tx_cnt_q <= tx_cnt_q - 1'b1;
          if (tx_cnt_q == 1 && tx_nbit_q != '0) tx_nbit_q <= tx_nbit_q - 1'b1;
        end
      end
    end
  end

  assign tx = tx_q;
  assign tx_oe = tx_oe_q;
endmodule // modbus_rtu_register_slave
`default_nettype wire

// [modbus_rtu_register_slave_chk.sv]
/*
  Concurrent checks on the ports of the Modbus RTU slave.
  Assumes one clock, synchronous active-high reset, bound to every slave instance.
*/
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_chk
  import modbus_pkg::*;
#(
  parameter int MIN_DIV = int'(MIN_BAUD_DIV) // smallest accepted bit divisor
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic tx, // transmit line
  input wire logic tx_oe, // driver enable
  input wire logic baud_cfg_en, // rate select
  input wire logic [modbus_pkg::BAUD_DIV_W-1:0] baud_cfg_div, // clocks per bit
  input wire logic rd_en, // read strobe
  input wire logic [15:0] rd_addr, // read address
  input wire logic wr_en, // write strobe
  input wire logic [15:0] wr_addr // write address
);
  logic tx_q;
  logic oe_q;
  logic [31:0] run_q;
  logic rd_seen_q;
  logic [15:0] rd_last_q;
  wire logic div_ok = baud_cfg_en && baud_cfg_div >= BAUD_DIV_W'(MIN_DIV) && baud_cfg_div <= MAX_BAUD_DIV;
  wire logic [31:0] exp_div = 32'(div_ok ? baud_cfg_div : DEFAULT_BAUD_DIV);
  // run_q holds how long tx kept its previous level, so every low run must be whole bits
  always_ff @(posedge clk) begin
    tx_q <= tx;
    oe_q <= tx_oe;
    run_q <= (rst || tx != tx_q) ? 32'h1 : run_q + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || (oe_q && !tx_oe)) begin
      rd_seen_q <= 1'b0;
    end else if (rd_en) begin
      rd_seen_q <= 1'b1;
      rd_last_q <= rd_addr;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_gap;
    !rd_en ##1 !rd_en;
  endsequence
  sequence s_stop_held;
    tx && $past(tx);
  endsequence
  a_quiet_reset: assert property (disable iff (1'b0) rst |=> tx && !tx_oe && !rd_en && !wr_en)
    else $error("outputs not quiet after reset");
  a_idle_line_high: assert property (!tx_oe |-> tx)
    else $error("tx low while driver off");
  a_oe_leads_start: assert property ($rose(tx_oe) |-> tx)
    else $error("driver enabled together with start bit");
  a_oe_after_stop: assert property ($fell(tx_oe) |-> s_stop_held)
    else $error("driver released inside a character");
  a_whole_bit_len: assert property ($rose(tx) && tx_oe |-> (run_q % exp_div) == 32'h0)
    else $error("low run on tx not a whole number of bits");
  a_rd_pulse_gap: assert property (rd_en |=> s_rd_gap)
    else $error("read strobes closer than three cycles");
  a_rd_addr_step: assert property (rd_en && rd_seen_q |-> rd_addr == rd_last_q + 16'h1)
    else $error("read address not consecutive");
  a_wr_addr_step: assert property (wr_en && $past(wr_en) |-> wr_addr == $past(wr_addr) + 16'h1)
    else $error("write address not consecutive");
  a_no_wr_reply: assert property (tx_oe |-> !wr_en)
    else $error("register write during reply");
endmodule // modbus_slave_chk
bind modbus_rtu_register_slave modbus_slave_chk #(.MIN_DIV(MIN_DIV)) u_modbus_slave_chk (.clk(clk), .rst(rst),
  .tx(tx), .tx_oe(tx_oe),
  .baud_cfg_en(baud_cfg_en), .baud_cfg_div(baud_cfg_div), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
  .wr_addr(wr_addr));
`default_nettype wire

// [modbus_rtu_register_slave_test.sv]
/*
  Self-checking bench: master model on the line, register store on the side port.
  Assumes the minimum divisor so frames stay short; expectations queued by the driver.
*/
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_register_slave_test;
  import modbus_pkg::*;
  typedef logic [7:0] bytes_type [$];
  // a short bit time keeps whole frames within a brief run
  localparam int BIT = 16;
  logic clk, rst, baud_cfg_en, station_cfg_en, tx, tx_oe, rd_en, wr_en, rx_strobe, rx_bad, host_line;
  logic [BAUD_DIV_W-1:0] baud_cfg_div;
  logic [7:0] station_cfg, rx_byte, st, fc;
  logic [15:0] rd_addr, rd_data, wr_addr, wr_data, s, w0, w1;
  logic [15:0] mem [16];
  logic [31:0] exp_wr [$];
  logic [7:0] exp_q [$];
  bytes_type none;
  int mismatches, n_tests;
  // the pair is biased to idle high whenever the slave releases it
  wire logic bus_line = tx_oe ? tx : 1'b1;
  modbus_rtu_register_slave #(.MIN_DIV(BIT)) u_modbus_rtu_register_slave (.clk(clk), .rst(rst), .rx(host_line), .tx(tx),
    .tx_oe(tx_oe), .baud_cfg_en(baud_cfg_en), .baud_cfg_div(baud_cfg_div), .station_cfg_en(station_cfg_en),
    .station_cfg(station_cfg), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data));
  modbus_master_model #(.BIT_DIV(BIT)) u_modbus_master_model (.clk(clk), .line_out(host_line),
    .line_in(bus_line), .rx_byte(rx_byte), .rx_strobe(rx_strobe), .rx_bad(rx_bad));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] crc16(bytes_type b);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // the master waits for the whole reply plus a silence before its next request
  task automatic transact(input bytes_type req, input bytes_type rep);
    logic [15:0] c;
    c = crc16(rep);
    if (rep.size() > 0) begin
      foreach (rep[i]) exp_q.push_back(rep[i]);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
    c = crc16(req);
    req.push_back(c[7:0]);
    req.push_back(c[15:8]);
    foreach (req[i]) u_modbus_master_model.send_byte(req[i]);
    for (int i = 0; i < 400 * BIT && (exp_q.size() > 0 || tx_oe !== 1'b0); i++) @(posedge clk);
    check("reply bytes left", exp_q.size(), 32'h0);
    repeat (45 * BIT) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rx_strobe === 1'b1) begin
      check("reply byte", {24'h0, rx_byte}, exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 'x);
      check("reply framing", {31'h0, rx_bad}, 32'h0);
    end
    if (wr_en === 1'b1) begin
      check("register write", {wr_addr, wr_data}, exp_wr.size() > 0 ? exp_wr.pop_front() : 'x);
      mem[wr_addr[3:0]] <= wr_data;
    end
    if (rd_en === 1'b1) rd_data <= mem[rd_addr[3:0]];
  end
  initial begin
    rst = 1'b1;
    baud_cfg_en = 1'b1;
    baud_cfg_div = BAUD_DIV_W'(BIT);
    station_cfg_en = 1'b0;
    station_cfg = 8'h00;
    rd_data = 16'h0000;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(40));
    foreach (mem[i]) mem[i] = 16'($urandom);
    s = 16'($urandom_range(0, 13));
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    st = 8'($urandom_range(43, 247));
    fc = 8'($urandom_range(4, 15));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    exp_wr.push_back({s, w0});
    exp_wr.push_back({s + 16'h0001, w1});
    transact('{DEFAULT_STATION, FC_WRITE, s[15:8], s[7:0], 8'h00, 8'h02, 8'h04, w0[15:8], w0[7:0], w1[15:8],
      w1[7:0]}, '{DEFAULT_STATION, FC_WRITE, s[15:8], s[7:0], 8'h00, 8'h02});
    // read back both written words and one untouched word above them
    transact('{DEFAULT_STATION, FC_READ, s[15:8], s[7:0], 8'h00, 8'h03}, '{DEFAULT_STATION, FC_READ, 8'h06,
      w0[15:8], w0[7:0], w1[15:8], w1[7:0], mem[s+2][15:8], mem[s+2][7:0]});
    station_cfg <= st;
    station_cfg_en <= 1'b1;
    @(posedge clk);
    transact('{DEFAULT_STATION, FC_READ, 8'h00, 8'h00, 8'h00, 8'h01}, none);
    transact('{st, fc, 8'h00, 8'h00, 8'h00, 8'h01}, '{st, fc | EXC_FLAG, EXC_ILLEGAL_FUNC});
    complete_run();
  end
  // about 1,000 bit times of traffic are expected; 100,000 cycles cuts a hang short
  initial begin
    #400_000;
    mismatches = mismatches + 1;
    complete_run();
  end
endmodule // modbus_rtu_register_slave_test
`default_nettype wire
